// *** rtl/mhic_pkg.sv ***
// Constants for the modem host interface control block.
// Assumes a single 200 MHz clock and an asynchronous active-high reset.
package mhic_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DEFAULT_BAUD = 19_200;
  localparam logic [15:0] DEFAULT_BAUD_DIV = 16'(CLK_HZ / DEFAULT_BAUD);
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam logic [6:0] WAIT_MIN_S = 7'd4;
  localparam logic [6:0] WAIT_MAX_S = 7'd120;
  localparam logic [6:0] WAIT_STEP_S = 7'd4;
  localparam logic [6:0] REFRESH_S = 7'd4;
  localparam logic [7:0] BAR_DB_HALF = 8'h04;
  typedef enum logic [2:0]
  {
    MHIC_WAIT = 3'b001,
    MHIC_SEARCH = 3'b010,
    MHIC_SESSION = 3'b100
  } mhic_net_e;
endpackage

// *** rtl/mhic_uart_rx.sv ***
// Serial receiver, 8N1, one character at a time.
// Assumes the line input is already synchronised to clk.
`timescale 1ns/1ps
module mhic_uart_rx
  import mhic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] baud_div,
  input wire logic line,
  output logic [7:0] data,
  output logic valid
);
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic busy_q;
  logic [7:0] sh_q;
  wire logic bit_end = (cnt_q == 16'h0000);
  wire logic [15:0] half_div = {1'b0, baud_div[15:1]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      busy_q <= 1'b0;
      sh_q <= 8'h00;
      data <= 8'h00;
      valid <= 1'b0;
    end
    else
    begin
      valid <= 1'b0;
      if (!busy_q)
      begin
        if (!line)
        begin
          busy_q <= 1'b1;
          cnt_q <= half_div;
          bit_q <= 4'h0;
        end
      end
      else if (!bit_end)
        cnt_q <= cnt_q - 16'h0001;
      else
      begin
        cnt_q <= baud_div - 16'h0001;
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h0 && line)
          busy_q <= 1'b0; // False start rejected
        else if (bit_q == 4'(DATA_BITS + 1))
        begin
          busy_q <= 1'b0;
          valid <= line; // Framing error drops the character
          data <= sh_q;
        end
        else if (bit_q != 4'h0)
          sh_q <= {line, sh_q[7:1]};
      end
    end
  end
endmodule // mhic_uart_rx

// *** rtl/mhic_uart_tx.sv ***
// Serial transmitter, 8N1, with a hold input that stalls between characters.
// Assumes data and control come from logic on clk.
`timescale 1ns/1ps
module mhic_uart_tx
  import mhic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] baud_div,
  input wire logic hold,
  input wire logic [7:0] data,
  input wire logic valid,
  output logic ready,
  output logic line
);
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic busy_q;
  logic [9:0] sh_q;
  // Only a slot that was offered as ready is taken, so no character goes out twice
  wire logic take = valid && ready;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      busy_q <= 1'b0;
      sh_q <= 10'h3ff;
      line <= 1'b1;
      ready <= 1'b0;
    end
    else
    begin
      ready <= !busy_q && !hold && !take;
      if (take)
      begin
        busy_q <= 1'b1;
        sh_q <= {1'b1, data, 1'b0}; // Start, 8 data, stop
        cnt_q <= 16'h0000;
        bit_q <= 4'h0;
      end
      else if (busy_q)
      begin
        if (cnt_q == 16'h0000)
        begin
          if (bit_q == 4'(DATA_BITS + 2))
            busy_q <= 1'b0;
          else
          begin
            line <= sh_q[0];
            sh_q <= {1'b1, sh_q[9:1]};
            bit_q <= bit_q + 4'h1;
            cnt_q <= baud_div - 16'h0001;
          end
        end
        else
          cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule // mhic_uart_tx

// *** rtl/mhic_top.sv ***
// Host-facing control of the short-message modem: serial port, handshake
// lines, power control, supply indicator and network availability.
// Assumes pins arrive asynchronously; all other inputs come from logic on clk.
`timescale 1ns/1ps
module mhic_top
  import mhic_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic rts_n_pin,
  input wire logic dtr_n_pin,
  output logic dcd_n_pin,
  output logic dsr_n_pin,
  output logic cts_n_pin,
  output logic ri_n_pin,
  input wire logic power_on_control,
  output logic supply_indicator_out,
  output logic network_available_out,
  output logic net_event_report,
  input wire logic rate_load,
  input wire logic [15:0] rate_div,
  input wire logic terminal_ready_mode,
  input wire logic flow_ctrl_en,
  input wire logic data_mode,
  input wire logic host_rx_ready,
  output logic [7:0] host_rx_data,
  output logic host_rx_valid,
  input wire logic [7:0] host_tx_data,
  input wire logic host_tx_valid,
  output logic host_tx_ready,
  output logic dtr_dropped,
  input wire logic message_waiting,
  input wire logic ring_found,
  input wire logic ring_missed,
  input wire logic session_start,
  input wire logic session_end,
  output logic ring_search_req,
  output logic [6:0] search_wait_s,
  input wire logic [7:0] sig_half_db,
  output logic [3:0] sig_bars
);
  // Two-flop synchronisers for pins
  logic [1:0] rxd_s_q;
  logic [1:0] rts_s_q;
  logic [1:0] dtr_s_q;
  logic [1:0] pwr_s_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_s_q <= 2'b11;
      rts_s_q <= 2'b11;
      dtr_s_q <= 2'b11;
      pwr_s_q <= 2'b00;
    end
    else
    begin
      rxd_s_q <= {rxd_s_q[0], serial_in_pin};
      rts_s_q <= {rts_s_q[0], rts_n_pin};
      dtr_s_q <= {dtr_s_q[0], dtr_n_pin};
      pwr_s_q <= {pwr_s_q[0], power_on_control};
    end
  end
  wire logic rxd = rxd_s_q[1];
  wire logic rts_off = rts_s_q[1];
  wire logic dtr_off = dtr_s_q[1];
  wire logic run = pwr_s_q[1];

  // Baud divider, set only by the rate command
  logic [15:0] baud_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      baud_q <= DEFAULT_BAUD_DIV;
    else if (rate_load && rate_div != 16'h0000)
      baud_q <= rate_div;
  end

  // Handshake decisions
  wire logic flow_active = flow_ctrl_en && data_mode;
  wire logic tx_hold = !run || (flow_active && rts_off);
  wire logic cts_off_d = flow_active && !host_rx_ready;
  wire logic dtr_drop_d = terminal_ready_mode && dtr_off;

  wire logic [7:0] rx_data;
  wire logic rx_valid;
  wire logic tx_ready;
  wire logic tx_line;

  // Bar count saturates instead of wrapping on strong signals
  wire logic [7:0] bars_full = sig_half_db / BAR_DB_HALF;
  wire logic [3:0] bars_sat = (bars_full > 8'h0f) ? 4'hf : bars_full[3:0];

  mhic_uart_rx u_rx
  (
    .clk(clk),
    .rst(rst),
    .baud_div(baud_q),
    .line(rxd),
    .data(rx_data),
    .valid(rx_valid)
  );

  mhic_uart_tx u_tx
  (
    .clk(clk),
    .rst(rst),
    .baud_div(baud_q),
    .hold(tx_hold),
    .data(host_tx_data),
    .valid(host_tx_valid),
    .ready(tx_ready),
    .line(tx_line)
  );

  // Pin and status outputs, all registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serial_out_pin <= 1'b1;
      dcd_n_pin <= 1'b1;
      dsr_n_pin <= 1'b1;
      cts_n_pin <= 1'b1;
      ri_n_pin <= 1'b1;
      supply_indicator_out <= 1'b0;
      host_rx_data <= 8'h00;
      host_rx_valid <= 1'b0;
      dtr_dropped <= 1'b0;
      sig_bars <= 4'h0;
    end
    else
    begin
      serial_out_pin <= tx_line;
      dcd_n_pin <= !run;
      dsr_n_pin <= !run;
      cts_n_pin <= !run || cts_off_d;
      ri_n_pin <= !(run && message_waiting);
      supply_indicator_out <= run;
      host_rx_data <= rx_data;
      host_rx_valid <= rx_valid && run;
      dtr_dropped <= run && dtr_drop_d;
      sig_bars <= bars_sat;
    end
  end
  assign host_tx_ready = tx_ready;

  // One-second tick
  // Restarted outside the wait state so each wait lasts whole seconds
  mhic_net_e st_q;
  logic [31:0] sec_cnt_q;
  wire logic sec_tick = (sec_cnt_q == 32'(SEC_CYC - 1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sec_cnt_q <= 32'h0000_0000;
    else if (sec_tick || !run || st_q != MHIC_WAIT)
      sec_cnt_q <= 32'h0000_0000;
    else
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
  end

  // Network availability and ring search back-off
  mhic_net_e st_d;
  logic [6:0] backoff_q;
  logic [6:0] backoff_d;
  logic [6:0] left_q;
  logic [6:0] left_d;
  logic avail_q;
  logic avail_d;
  logic req_d;

  wire logic [7:0] backoff_sum = {1'b0, backoff_q} + {1'b0, WAIT_STEP_S};
  wire logic [6:0] backoff_up =
    (backoff_sum > {1'b0, WAIT_MAX_S}) ? WAIT_MAX_S : backoff_sum[6:0];
  wire logic wait_done = sec_tick && (left_q <= 7'd1);

  always_comb
  begin
    st_d = st_q;
    backoff_d = backoff_q;
    left_d = left_q;
    avail_d = avail_q;
    req_d = 1'b0;
    unique case (st_q)
      MHIC_WAIT:
      begin
        if (session_start)
        begin
          st_d = MHIC_SESSION;
          avail_d = 1'b0;
          req_d = !avail_q;
        end
        else if (wait_done)
        begin
          st_d = MHIC_SEARCH;
          req_d = 1'b1;
        end
        else if (sec_tick)
          left_d = left_q - 7'd1;
      end
      MHIC_SEARCH:
      begin
        if (session_start)
        begin
          st_d = MHIC_SESSION;
          avail_d = 1'b0;
          req_d = 1'b1;
        end
        else if (ring_found)
        begin
          st_d = MHIC_WAIT;
          avail_d = 1'b1;
          backoff_d = WAIT_MIN_S;
          left_d = REFRESH_S;
        end
        else if (ring_missed)
        begin
          st_d = MHIC_WAIT;
          avail_d = 1'b0;
          backoff_d = backoff_up;
          left_d = backoff_up;
        end
      end
      MHIC_SESSION:
      begin
        avail_d = 1'b0;
        if (ring_found)
          backoff_d = WAIT_MIN_S;
        // Session miss keeps back-off as is
        if (session_end)
        begin
          st_d = MHIC_SEARCH;
          req_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= MHIC_SEARCH;
      backoff_q <= WAIT_MIN_S;
      left_q <= WAIT_MIN_S;
      avail_q <= 1'b0;
      ring_search_req <= 1'b0;
    end
    else if (!run)
    begin
      st_q <= MHIC_SEARCH;
      backoff_q <= WAIT_MIN_S;
      left_q <= WAIT_MIN_S;
      avail_q <= 1'b0;
      ring_search_req <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      backoff_q <= backoff_d;
      left_q <= left_d;
      avail_q <= avail_d;
      ring_search_req <= req_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      network_available_out <= 1'b0;
      net_event_report <= 1'b0;
      search_wait_s <= WAIT_MIN_S;
    end
    else
    begin
      network_available_out <= avail_q;
      net_event_report <= avail_q;
      search_wait_s <= backoff_q;
    end
  end
endmodule // mhic_top

// *** tb/mhic_properties.sv ***
// Port checker for mhic_top.
// Assumes it is bound into mhic_top and sees only its ports.
`timescale 1ns/1ps
module mhic_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic power_on_control,
  input wire logic supply_indicator_out,
  input wire logic dcd_n_pin,
  input wire logic cts_n_pin,
  input wire logic ri_n_pin,
  input wire logic data_mode,
  input wire logic flow_ctrl_en,
  input wire logic message_waiting,
  input wire logic network_available_out,
  input wire logic net_event_report,
  input wire logic ring_found,
  input wire logic [6:0] search_wait_s,
  input wire logic [7:0] sig_half_db,
  input wire logic [3:0] sig_bars
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_event_mirror: assert property (net_event_report == network_available_out)
    else $error("event report differs from output");
  a_cmd_cts_on: assert property ((!data_mode && supply_indicator_out)[*3] |-> !cts_n_pin)
    else $error("cts off in command mode");
  a_three_wire: assert property ((!flow_ctrl_en && supply_indicator_out)[*3]
    |-> !cts_n_pin && !dcd_n_pin)
    else $error("cts or dcd off without flow control");
  a_power_off: assert property (!power_on_control[*5]
    |-> !supply_indicator_out && cts_n_pin && dcd_n_pin)
    else $error("still running with control low");
  a_ring_on: assert property ((message_waiting && supply_indicator_out)[*2] |-> !ri_n_pin)
    else $error("ring not shown");
  a_net_cause: assert property ($rose(network_available_out) |-> $past(ring_found, 2))
    else $error("network up without ring reception");
  a_wait_step: assert property ($changed(search_wait_s) |-> search_wait_s <= 7'h78
    && (search_wait_s == $past(search_wait_s) + 7'h04 || search_wait_s == 7'h04))
    else $error("bad back-off step");
  a_bar_scale: assert property (!$past(rst) && $past(supply_indicator_out)
    && supply_indicator_out && $past(sig_half_db) < 8'h40 |-> sig_bars == $past(sig_half_db[5:2]))
    else $error("bar count wrong");
  a_bar_limit: assert property (!$past(rst) && $past(supply_indicator_out)
    && supply_indicator_out && $past(sig_half_db) >= 8'h40 |-> sig_bars == 4'hf)
    else $error("bar count not saturated");
endmodule // mhic_properties

bind mhic_top mhic_properties chk_u (.clk, .rst, .power_on_control, .supply_indicator_out,
  .dcd_n_pin, .cts_n_pin, .ri_n_pin, .data_mode, .flow_ctrl_en, .message_waiting,
  .network_available_out, .net_event_report, .ring_found, .search_wait_s, .sig_half_db,
  .sig_bars);

// *** tb/mhic_host_model.sv ***
// Host terminal model: sends and receives 8N1 characters.
// Assumes bit_div clk cycles per bit, matching the loaded divisor.
`timescale 1ns/1ps
module mhic_host_model
(
  input wire logic clk,
  input wire logic [15:0] bit_div,
  input wire logic rx_en,
  input wire logic rxd,
  output logic txd,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  logic [7:0] sh;
  initial txd = 1'b1;
  initial rx_stb = 1'b0;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      txd = f[i];
      repeat (bit_div - 1) @(negedge clk);
    end
  endtask
  // Mid-bit sampling, stop bit must be high
  always
  begin
    @(negedge rxd iff rx_en);
    repeat (bit_div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_div) @(posedge clk);
      sh[i] = rxd;
    end
    repeat (bit_div) @(posedge clk);
    rx_byte = sh;
    rx_stb = rxd;
    @(posedge clk);
    rx_stb = 1'b0;
  end
endmodule // mhic_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for mhic_top with a host terminal model.
// Assumes SEC_CYC shortened to 20 cycles per second.
`timescale 1ns/1ps
module tb_top;
  import mhic_pkg::*;
  localparam int SC = 20;
  logic clk, rst, serial_in_pin, serial_out_pin, rts_n_pin, dtr_n_pin, dcd_n_pin, dsr_n_pin;
  logic cts_n_pin, ri_n_pin, power_on_control, supply_indicator_out, network_available_out;
  logic net_event_report, rate_load, terminal_ready_mode, flow_ctrl_en, data_mode, rx_en;
  logic host_rx_ready, host_rx_valid, host_tx_valid, host_tx_ready, dtr_dropped, rx_stb;
  logic message_waiting, ring_found, ring_missed, session_start, session_end, ring_search_req;
  logic [15:0] rate_div, bit_div;
  logic [7:0] host_rx_data, host_tx_data, sig_half_db, rx_byte;
  logic [6:0] search_wait_s;
  logic [3:0] sig_bars;
  logic [7:0] exp_rx[$], exp_tx[$];
  int err_total, num_checks, cyc, n, seed;
  mhic_top #(.SEC_CYC(SC)) dut_u (.clk, .rst, .serial_in_pin, .serial_out_pin, .rts_n_pin,
    .dtr_n_pin, .dcd_n_pin, .dsr_n_pin, .cts_n_pin, .ri_n_pin, .power_on_control,
    .supply_indicator_out, .network_available_out, .net_event_report, .rate_load, .rate_div,
    .terminal_ready_mode, .flow_ctrl_en, .data_mode, .host_rx_ready, .host_rx_data,
    .host_rx_valid, .host_tx_data, .host_tx_valid, .host_tx_ready, .dtr_dropped,
    .message_waiting, .ring_found, .ring_missed, .session_start, .session_end,
    .ring_search_req, .search_wait_s, .sig_half_db, .sig_bars);
  mhic_host_model host_u (.clk, .bit_div, .rx_en, .rxd(serial_out_pin), .txd(serial_in_pin),
    .rx_byte, .rx_stb);
  always #2.5 clk = ~clk;
  task automatic chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_byte(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Order: found, missed, session start, session end
  task automatic ev(input logic [3:0] v);
    @(negedge clk);
    {ring_found, ring_missed, session_start, session_end} = v;
    @(negedge clk);
    {ring_found, ring_missed, session_start, session_end} = 4'h0;
  endtask
  task automatic wait_req;
    n = 0;
    while (ring_search_req !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
      err_total++;
  endtask
  task automatic dev_send(input logic [7:0] v);
    @(negedge clk);
    host_tx_data = v;
    host_tx_valid = 1'b1;
    while (host_tx_ready !== 1'b1)
      @(negedge clk);
    exp_tx.push_back(v);
    @(negedge clk);
    host_tx_valid = 1'b0;
  endtask
  task automatic host_send(input logic [7:0] v);
    while (cts_n_pin !== 1'b0)
      @(negedge clk);
    exp_rx.push_back(v);
    host_u.send(v);
  endtask
  always @(negedge clk)
  begin
    if (host_rx_valid === 1'b1)
      chk_byte("rx", exp_rx.size() ? exp_rx.pop_front() : 8'hxx, host_rx_data);
    if (rx_stb === 1'b1)
      chk_byte("tx", exp_tx.size() ? exp_tx.pop_front() : 8'hxx, rx_byte);
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    {clk, rst, rts_n_pin, dtr_n_pin, power_on_control, rate_load} = 6'h1a;
    {terminal_ready_mode, flow_ctrl_en, data_mode, host_rx_ready, rx_en} = 5'h1a;
    {message_waiting, ring_found, ring_missed, session_start, session_end} = 5'h00;
    {host_tx_data, host_tx_valid, sig_half_db} = 17'h00000;
    {rate_div, bit_div} = {16'h0010, DEFAULT_BAUD_DIV};
    {err_total, num_checks, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd6};
    tick(16);
    rst = 1'b0;
    @(negedge clk);
    host_tx_data = 8'hff;
    host_tx_valid = 1'b1;
    n = 0;
    while (serial_out_pin !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    host_tx_valid = 1'b0;
    n = 0;
    while (serial_out_pin === 1'b0 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    chk_val("baud", DEFAULT_BAUD_DIV, n[15:0]);
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    $display("done default rate");
    rate_load = 1'b1;
    tick(1);
    rate_load = 1'b0;
    bit_div = 16'h0010;
    rx_en = 1'b1;
    data_mode = 1'b1;
    rts_n_pin = 1'b0;
    fork
      for (int i = 0; i < 4; i++) host_send(8'($random(seed)));
      for (int i = 0; i < 4; i++) dev_send(8'($random(seed)));
    join
    tick(200);
    rts_n_pin = 1'b1;
    tick(4);
    fork
      dev_send(8'h5a);
      begin
        tick(40);
        chk_val("stall", 1, serial_out_pin);
        chk_val("hold", 0, host_tx_ready);
        rts_n_pin = 1'b0;
      end
    join
    tick(200);
    data_mode = 1'b0;
    rts_n_pin = 1'b1;
    dev_send(8'ha5);
    tick(200);
    chk_val("left", 0, 16'(exp_rx.size() + exp_tx.size()));
    $display("done serial");
    for (int i = 0; i < 16; i++)
    begin
      {terminal_ready_mode, data_mode, flow_ctrl_en, host_rx_ready} = 4'(i);
      message_waiting = i[0];
      dtr_n_pin = i[1];
      tick(6);
      chk_val("cts", data_mode & flow_ctrl_en & ~host_rx_ready, cts_n_pin);
      chk_val("ri", !message_waiting, ri_n_pin);
      chk_val("dtr", terminal_ready_mode & dtr_n_pin, dtr_dropped);
      chk_val("dcd", 0, dcd_n_pin);
    end
    {terminal_ready_mode, data_mode, flow_ctrl_en} = 3'h0;
    $display("done handshake");
    while (exp_rx.size() + exp_tx.size() != 0)
      tick(1);
    {rts_n_pin, dtr_n_pin} = 2'b11;
    power_on_control = 1'b0;
    tick(8);
    chk_val("off", 3, {supply_indicator_out, dsr_n_pin, cts_n_pin});
    tick(2 * SC + 1);
    power_on_control = 1'b1;
    tick(8);
    chk_val("on", 4, {supply_indicator_out, dsr_n_pin, cts_n_pin});
    $display("done power");
    for (int k = 1; k <= 30; k++)
    begin
      ev(4'h4);
      tick(3);
      chk_val("backoff", (k > 28) ? 120 : 4 + 4 * k, search_wait_s);
      chk_val("net", 0, network_available_out);
      wait_req;
    end
    ev(4'h8);
    wait_req;
    chk_val("refresh", 1, n > 73 && n < 87);
    chk_val("net", 3, {network_available_out, net_event_report});
    chk_val("wait", 4, search_wait_s);
    ev(4'h8);
    ev(4'h2);
    tick(2);
    chk_val("session", 0, network_available_out);
    ev(4'h1);
    wait_req;
    ev(4'h8);
    tick(3);
    chk_val("after", 1, network_available_out);
    wait_req;
    ev(4'h4);
    ev(4'h2);
    wait_req;
    chk_val("forced", 1, n < 8);
    ev(4'h4);
    tick(3);
    chk_val("kept", 8, search_wait_s);
    ev(4'h1);
    wait_req;
    ev(4'h8);
    tick(3);
    chk_val("back", 1, network_available_out);
    $display("done network");
    for (int i = 0; i < 8; i++)
    begin
      sig_half_db = 8'($random(seed));
      tick(3);
      chk_val("bars", (sig_half_db > 8'h3f) ? 16'h000f : 16'(sig_half_db[5:2]), sig_bars);
    end
    $display("done bars");
    report_and_stop();
  end
endmodule // tb_top
